/* design/mfo_pkg.sv */
package mfo_pkg;
	// output function codes shared by the relay pair and the auxiliary contact
	localparam int CODE_W = 5;
	localparam logic [4:0] FN_FAULT = 5'h00;
	localparam logic [4:0] FN_RUN = 5'h01;
	localparam logic [4:0] FN_FREQ_AGREE = 5'h02;
	localparam logic [4:0] FN_DESIRED_AGREE = 5'h03;
	localparam logic [4:0] FN_FREQ_DET1 = 5'h04;
	localparam logic [4:0] FN_FREQ_DET2 = 5'h05;
	localparam logic [4:0] FN_OVERTORQUE_NO = 5'h06;
	localparam logic [4:0] FN_OVERTORQUE_NC = 5'h07;
	localparam logic [4:0] FN_BASEBLOCK = 5'h08;
	localparam logic [4:0] FN_OPERATOR_MODE = 5'h09;
	localparam logic [4:0] FN_READY = 5'h0A;
	localparam logic [4:0] FN_TIMER = 5'h0B;
	localparam logic [4:0] FN_RESTART = 5'h0C;
	localparam logic [4:0] FN_OVERLOAD_PRE = 5'h0D;
	localparam logic [4:0] FN_REF_LOSS = 5'h0E;
	localparam logic [4:0] FN_SERIAL = 5'h0F;
	localparam logic [4:0] FN_FEEDBACK_LOSS = 5'h10;
	localparam logic [4:0] FN_HEATSINK_ALARM = 5'h11;

	localparam logic [4:0] RELAY_FN_RST = FN_FAULT;
	localparam logic [4:0] AUX_FN_RST = FN_RUN;

	localparam logic RETAIN_KEEP = 1'b0;
	localparam logic LOSS_CONTINUE = 1'b1;

	// percentages
	localparam logic [7:0] PCT_FULL = 8'h64;
	localparam logic [7:0] LOSS_DROP_PCT = 8'h5A;
	localparam logic [7:0] FALLBACK_PCT = 8'h50;
	localparam logic [7:0] DRIVE_OL_PCT = 8'h96;
	localparam logic [7:0] MOTOR_PRE_PCT = 8'h50;

	// timing, times in their own unit, counts derived at 250 MHz
	localparam int CLK_PERIOD_PS = 4000;
	localparam int MS_PS = 1000000000;
	localparam int MS_CYC_DEF = MS_PS / CLK_PERIOD_PS;
	localparam int LOSS_WIN_MS = 400;
	localparam int DRIVE_OL_S = 48;
	localparam int DRIVE_OL_MS = DRIVE_OL_S * 1000;

	typedef struct packed {
		logic fault;
		logic forward_run;
		logic reverse_run;
		logic out_voltage;
		logic baseblock;
		logic operator_run_src;
		logic operator_ref_src;
		logic drive_ready;
		logic fault_retry;
		logic freq_agree;
		logic desired_freq_agree;
		logic freq_det1;
		logic freq_det2;
		logic overtorque;
		logic timer_out;
		logic serial_out;
		logic heatsink_overheat_alarm;
	} mfo_status_t;

	typedef struct packed {
		logic overload_pre;
		logic ref_loss;
		logic feedback_loss;
	} mfo_det_t;
endpackage : mfo_pkg

/* design/mfo_sel.sv */
`timescale 1ns/1ps
module mfo_sel (
	input wire logic [mfo_pkg::CODE_W-1:0] code_i,
	input wire mfo_pkg::mfo_status_t status_i,
	input wire mfo_pkg::mfo_det_t det_i,
	output logic closed_o
);
	import mfo_pkg::*;

	always_comb begin
		case (code_i)
			FN_FAULT: closed_o = status_i.fault;
			FN_RUN: closed_o = status_i.forward_run | status_i.reverse_run | status_i.out_voltage;
			FN_FREQ_AGREE: closed_o = status_i.freq_agree;
			FN_DESIRED_AGREE: closed_o = status_i.desired_freq_agree;
			FN_FREQ_DET1: closed_o = status_i.freq_det1;
			FN_FREQ_DET2: closed_o = status_i.freq_det2;
			FN_OVERTORQUE_NO: closed_o = status_i.overtorque;
			FN_OVERTORQUE_NC: closed_o = ~status_i.overtorque;
			FN_BASEBLOCK: closed_o = status_i.baseblock;
			FN_OPERATOR_MODE: closed_o = status_i.operator_run_src | status_i.operator_ref_src;
			FN_READY: closed_o = ~status_i.fault & status_i.drive_ready;
			FN_TIMER: closed_o = status_i.timer_out;
			FN_RESTART: closed_o = status_i.fault_retry;
			FN_OVERLOAD_PRE: closed_o = det_i.overload_pre;
			FN_REF_LOSS: closed_o = det_i.ref_loss;
			FN_SERIAL: closed_o = status_i.serial_out;
			FN_FEEDBACK_LOSS: closed_o = det_i.feedback_loss;
			FN_HEATSINK_ALARM: closed_o = status_i.heatsink_overheat_alarm;
			// unused codes keep the contact open, the safe state for wired equipment
			default: closed_o = 1'b0;
		endcase
	end
endmodule : mfo_sel

/* design/mfo_top.sv */
`timescale 1ns/1ps
module mfo_top #(
	parameter int REF_W = 16,
	parameter int MS_CYC = mfo_pkg::MS_CYC_DEF,
	parameter int LOSS_WIN_MS = mfo_pkg::LOSS_WIN_MS,
	parameter int DRIVE_OL_MS = mfo_pkg::DRIVE_OL_MS
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire mfo_pkg::mfo_status_t status_i,
	input wire logic [mfo_pkg::CODE_W-1:0] relay_fn_i,
	input wire logic [mfo_pkg::CODE_W-1:0] aux_fn_i,
	input wire logic fn_we_i,
	input wire logic reference_retention_select_i,
	input wire logic reference_loss_action_i,
	input wire logic updown_hold_used_i,
	input wire logic [REF_W-1:0] held_ref_i,
	input wire logic power_loss_i,
	input wire logic [REF_W-1:0] term_ref_i,
	input wire logic [7:0] load_pct_i,
	input wire logic [7:0] motor_ol_pct_i,
	input wire logic pid_mode_i,
	input wire logic [REF_W-1:0] feedback_i,
	input wire logic [REF_W-1:0] feedback_loss_level_i,
	input wire logic [15:0] feedback_loss_delay_i,
	output logic [mfo_pkg::CODE_W-1:0] relay_output_function_o,
	output logic [mfo_pkg::CODE_W-1:0] aux_output_function_o,
	output logic [REF_W-1:0] preset_reference_one_o,
	output logic preset_ref_we_o,
	output logic [REF_W-1:0] ref_o,
	output logic ref_loss_o,
	output logic overload_pre_o,
	output logic feedback_loss_o,
	output logic relay_contact_a_o,
	output logic relay_contact_b_o,
	output logic aux_contact_o
);
	import mfo_pkg::*;

	localparam int MS_W = $clog2(MS_CYC + 1);
	localparam int WIN_W = $clog2(LOSS_WIN_MS + 1);
	localparam int OL_W = $clog2(DRIVE_OL_MS + 1);

	if (MS_CYC < 1 || LOSS_WIN_MS < 1 || DRIVE_OL_MS < 1 || REF_W < 2) begin : g_chk
		$error("mfo_top: counts must be at least one and REF_W at least two");
	end

	typedef enum logic {LD_WATCH, LD_LOST} mfo_loss_t;

	function automatic logic [REF_W+7:0] pct(input logic [REF_W-1:0] v, input logic [7:0] p);
		pct = (REF_W+8)'(v) * (REF_W+8)'(p);
	endfunction : pct

	logic [MS_W-1:0] ms_cnt_q;
	logic ms_tick;
	logic [WIN_W-1:0] win_cnt_q;
	logic [REF_W-1:0] snap_q;
	logic [REF_W-1:0] hold_q;
	mfo_loss_t loss_q;
	logic drop_hit;
	logic [OL_W-1:0] ol_cnt_q;
	logic [15:0] fb_cnt_q;
	logic relay_closed;
	logic aux_closed;
	mfo_det_t det;

	assign ms_tick = (ms_cnt_q == MS_W'(MS_CYC - 1));
	// drop beyond 90% means the present value is under 10% of the window snapshot
	assign drop_hit = pct(term_ref_i, PCT_FULL) < pct(snap_q, PCT_FULL - LOSS_DROP_PCT);
	assign det = '{overload_pre: overload_pre_o, ref_loss: ref_loss_o, feedback_loss: feedback_loss_o};

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ms_cnt_q <= '0;
		end else if (ce_i) begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + MS_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			relay_output_function_o <= RELAY_FN_RST;
			aux_output_function_o <= AUX_FN_RST;
		end else if (ce_i && fn_we_i) begin
			relay_output_function_o <= relay_fn_i;
			aux_output_function_o <= aux_fn_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			preset_reference_one_o <= '0;
			preset_ref_we_o <= 1'b0;
		end else if (ce_i) begin
			preset_ref_we_o <= 1'b0;
			if (power_loss_i && updown_hold_used_i && reference_retention_select_i == RETAIN_KEEP) begin
				preset_reference_one_o <= held_ref_i;
				preset_ref_we_o <= 1'b1;
			end
		end
	end

	// the snapshot is refreshed once per window, so a drop is caught against a value 0 to 400ms old
	// never refreshed on a detecting edge, or the dropped value would end the loss at once
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			win_cnt_q <= '0;
			snap_q <= '0;
		end else if (ce_i && ms_tick && loss_q == LD_WATCH && !drop_hit) begin
			if (win_cnt_q == WIN_W'(LOSS_WIN_MS - 1)) begin
				win_cnt_q <= '0;
				snap_q <= term_ref_i;
			end else begin
				win_cnt_q <= win_cnt_q + WIN_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			loss_q <= LD_WATCH;
			hold_q <= '0;
			ref_loss_o <= 1'b0;
		end else if (ce_i) begin
			case (loss_q)
				LD_WATCH: begin
					if (drop_hit) begin
						loss_q <= LD_LOST;
						ref_loss_o <= 1'b1;
						hold_q <= REF_W'(pct(snap_q, FALLBACK_PCT) / (REF_W+8)'(PCT_FULL));
					end
				end
				LD_LOST: begin
					// recovery above the loss threshold ends the fallback
					if (!drop_hit) begin
						loss_q <= LD_WATCH;
						ref_loss_o <= 1'b0;
					end
				end
				default: begin
					loss_q <= LD_WATCH;
					ref_loss_o <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ref_o <= '0;
		end else if (ce_i) begin
			if (loss_q == LD_LOST && reference_loss_action_i == LOSS_CONTINUE) begin
				ref_o <= hold_q;
			end else begin
				ref_o <= term_ref_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ol_cnt_q <= '0;
			overload_pre_o <= 1'b0;
		end else if (ce_i) begin
			if (load_pct_i < DRIVE_OL_PCT) begin
				ol_cnt_q <= '0;
			end else if (ms_tick && ol_cnt_q != OL_W'(DRIVE_OL_MS)) begin
				ol_cnt_q <= ol_cnt_q + OL_W'(1);
			end
			overload_pre_o <= (ol_cnt_q == OL_W'(DRIVE_OL_MS)) || (motor_ol_pct_i > MOTOR_PRE_PCT);
		end
	end

	// delay counts in milliseconds and saturates, so long delays never wrap
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fb_cnt_q <= '0;
			feedback_loss_o <= 1'b0;
		end else if (ce_i) begin
			if (!pid_mode_i || feedback_i >= feedback_loss_level_i) begin
				fb_cnt_q <= '0;
				feedback_loss_o <= 1'b0;
			end else begin
				if (ms_tick && fb_cnt_q != 16'hFFFF) begin
					fb_cnt_q <= fb_cnt_q + 16'h0001;
				end
				feedback_loss_o <= fb_cnt_q > feedback_loss_delay_i;
			end
		end
	end

	mfo_sel u_relay_sel (
		.code_i(relay_output_function_o),
		.status_i(status_i),
		.det_i(det),
		.closed_o(relay_closed)
	);

	mfo_sel u_aux_sel (
		.code_i(aux_output_function_o),
		.status_i(status_i),
		.det_i(det),
		.closed_o(aux_closed)
	);

	// the b contact is the break side of the relay pair
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			relay_contact_a_o <= 1'b0;
			relay_contact_b_o <= 1'b1;
			aux_contact_o <= 1'b0;
		end else if (ce_i) begin
			relay_contact_a_o <= relay_closed;
			relay_contact_b_o <= ~relay_closed;
			aux_contact_o <= aux_closed;
		end
	end

	fn_reset_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(srst_i) |-> relay_output_function_o == FN_FAULT && aux_output_function_o == FN_RUN)
		else $error("function codes not at reset values");
	contact_pair_a: assert property (@(posedge clk_i) disable iff (srst_i)
		relay_contact_b_o == !relay_contact_a_o)
		else $error("relay b not opposite to relay a");
	retain_store_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && power_loss_i && updown_hold_used_i && !reference_retention_select_i
		|=> preset_ref_we_o && preset_reference_one_o == $past(held_ref_i))
		else $error("held reference not stored");
	retain_skip_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && reference_retention_select_i |=> !preset_ref_we_o)
		else $error("reference stored while retention off");
	loss_detect_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && drop_hit |=> ref_loss_o)
		else $error("reference loss not flagged");
	snap_freeze_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && drop_hit |=> $stable(snap_q))
		else $error("snapshot moved on a detected drop");
	fallback_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && ref_loss_o && reference_loss_action_i |=> ref_o == $past(hold_q))
		else $error("fallback reference not applied");
	fault_route_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && relay_output_function_o == FN_FAULT && !fn_we_i |=> relay_contact_a_o == $past(status_i.fault))
		else $error("fault not routed to relay");
	serial_route_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && aux_output_function_o == FN_SERIAL && !fn_we_i |=> aux_contact_o == $past(status_i.serial_out))
		else $error("serial command not routed to aux");
	overload_pre_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && ol_cnt_q == OL_W'(DRIVE_OL_MS) |=> overload_pre_o)
		else $error("overload pre-alarm missing");
	ce_freeze_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!ce_i |=> $stable(aux_contact_o) && $stable(ref_o))
		else $error("state moved with clock enable low");

	loss_seen_c: cover property (@(posedge clk_i) disable iff (srst_i) $rose(ref_loss_o));
	store_seen_c: cover property (@(posedge clk_i) disable iff (srst_i) preset_ref_we_o);
	pre_seen_c: cover property (@(posedge clk_i) disable iff (srst_i) $rose(overload_pre_o));
	fb_seen_c: cover property (@(posedge clk_i) disable iff (srst_i) $rose(feedback_loss_o));
endmodule : mfo_top

/* verif/mfo_contact_load.sv */
`timescale 1ns/1ps
module mfo_contact_load (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic relay_contact_a_i,
	input wire logic relay_contact_b_i,
	input wire logic aux_contact_i,
	output logic clash_o,
	output logic [7:0] aux_closures_o
);
	logic aux_q;
	// a pair whose two sides agree would short the wired load, so it latches until reset
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			clash_o <= 1'b0;
		end else if (relay_contact_a_i === relay_contact_b_i) begin
			clash_o <= 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		aux_q <= aux_contact_i;
		if (srst_i) begin
			aux_closures_o <= 8'h00;
		end else if (aux_contact_i && !aux_q) begin
			aux_closures_o <= aux_closures_o + 8'h01;
		end
	end
endmodule : mfo_contact_load

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import mfo_pkg::*;
	typedef struct packed {logic [4:0] code; logic [16:0] st; logic closed;} mfo_row_t;
	logic clk_i, srst_i, ce_i, fn_we, ret, act, ud, pl, pid;
	mfo_status_t st;
	logic [4:0] rfn, afn, rfo, afo;
	logic [15:0] held, term, fb, fb_lvl, fb_dly, pre, refo;
	logic [7:0] load, mol, clos;
	logic pwe, rloss, olp, fbl, ca, cb, cx, clash;
	int err_total, samples_checked;
	mfo_row_t rows [23] = '{
		'{5'h00, 17'h10000, 1'b1},
		'{5'h00, 17'h0FFFF, 1'b0},
		'{5'h01, 17'h04000, 1'b1},
		'{5'h01, 17'h02000, 1'b1},
		'{5'h01, 17'h10000, 1'b0},
		'{5'h02, 17'h00080, 1'b1},
		'{5'h03, 17'h00040, 1'b1},
		'{5'h04, 17'h00020, 1'b1},
		'{5'h05, 17'h00010, 1'b1},
		'{5'h06, 17'h00008, 1'b1},
		'{5'h07, 17'h00008, 1'b0},
		'{5'h07, 17'h00000, 1'b1},
		'{5'h08, 17'h01000, 1'b1},
		'{5'h09, 17'h00400, 1'b1},
		'{5'h09, 17'h00800, 1'b1},
		'{5'h0A, 17'h00200, 1'b1},
		'{5'h0A, 17'h10200, 1'b0},
		'{5'h0B, 17'h00004, 1'b1},
		'{5'h0C, 17'h00100, 1'b1},
		'{5'h0F, 17'h00002, 1'b1},
		'{5'h0F, 17'h1FFFD, 1'b0},
		'{5'h11, 17'h00001, 1'b1},
		'{5'h14, 17'h1FFFF, 1'b0}
	};
	// short counts keep the run brief; every expectation below follows from them
	mfo_top #(.MS_CYC(4), .LOSS_WIN_MS(4), .DRIVE_OL_MS(8)) dut_u (.clk_i(clk_i), .srst_i(srst_i),
		.ce_i(ce_i), .status_i(st), .relay_fn_i(rfn), .aux_fn_i(afn), .fn_we_i(fn_we),
		.reference_retention_select_i(ret), .reference_loss_action_i(act), .updown_hold_used_i(ud),
		.held_ref_i(held), .power_loss_i(pl), .term_ref_i(term), .load_pct_i(load), .motor_ol_pct_i(mol),
		.pid_mode_i(pid), .feedback_i(fb), .feedback_loss_level_i(fb_lvl), .feedback_loss_delay_i(fb_dly),
		.relay_output_function_o(rfo), .aux_output_function_o(afo), .preset_reference_one_o(pre),
		.preset_ref_we_o(pwe), .ref_o(refo), .ref_loss_o(rloss), .overload_pre_o(olp),
		.feedback_loss_o(fbl), .relay_contact_a_o(ca), .relay_contact_b_o(cb), .aux_contact_o(cx));
	mfo_contact_load load_u (.clk_i(clk_i), .srst_i(srst_i), .relay_contact_a_i(ca),
		.relay_contact_b_i(cb), .aux_contact_i(cx), .clash_o(clash), .aux_closures_o(clos));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic setfn(input logic [4:0] r, input logic [4:0] x);
		rfn = r;
		afn = x;
		fn_we = 1'b1;
		step(1);
		fn_we = 1'b0;
		step(2);
	endtask : setfn
	task automatic finish_test();
		$display("counts: %0d checked, %0d bad", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		#40000;
		err_total++;
		finish_test();
	end
	initial begin
		{ce_i, fn_we, ret, act, ud, pl, pid} = '0;
		st = '0;
		{rfn, afn, held, term, fb, fb_lvl, fb_dly, load, mol} = '0;
		srst_i = 1'b1;
		step(2);
		srst_i = 1'b0;
		ce_i = 1'b1;
		chk("relay_fn", rfo, 16'h0000);
		chk("aux_fn", afo, 16'h0001);
		chk("contact_b", cb, 16'h0001);
		chk("preset_we", pwe, 16'h0000);
		st.fault = 1'b1;
		st.forward_run = 1'b1;
		step(2);
		chk("contact_a", ca, 16'h0001);
		chk("aux", cx, 16'h0001);
		st = '0;
		// a write while frozen must be dropped
		ce_i = 1'b0;
		rfn = 5'h08;
		fn_we = 1'b1;
		step(1);
		fn_we = 1'b0;
		ce_i = 1'b1;
		step(1);
		chk("relay_fn", rfo, 16'h0000);
		$display("test reset done");
		foreach (rows[i]) begin
			st = mfo_status_t'(rows[i].st);
			setfn(rows[i].code, rows[i].code);
			chk("contact_a", ca, rows[i].closed);
			chk("contact_b", cb, !rows[i].closed);
			chk("aux", cx, rows[i].closed);
		end
		st = '0;
		$display("test table done");
		ud = 1'b1;
		held = 16'h1234;
		pl = 1'b1;
		step(1);
		pl = 1'b0;
		chk("preset_we", pwe, 16'h0001);
		chk("preset", pre, 16'h1234);
		step(1);
		chk("preset_we", pwe, 16'h0000);
		ret = 1'b1;
		held = 16'h5678;
		pl = 1'b1;
		step(1);
		pl = 1'b0;
		chk("preset_we", pwe, 16'h0000);
		chk("preset", pre, 16'h1234);
		ret = 1'b0;
		ud = 1'b0;
		pl = 1'b1;
		step(1);
		pl = 1'b0;
		chk("preset_we", pwe, 16'h0000);
		$display("test retention done");
		act = 1'b1;
		setfn(FN_REF_LOSS, FN_OVERLOAD_PRE);
		term = 16'h03E8;
		step(40);
		chk("ref_loss", rloss, 16'h0000);
		term = 16'h0032;
		step(1);
		chk("ref_loss", rloss, 16'h0001);
		step(1);
		chk("ref", refo, 16'h0320);
		chk("contact_a", ca, 16'h0001);
		// exactly a 90% fall is not more than 90%
		term = 16'h0064;
		step(3);
		chk("ref_loss", rloss, 16'h0000);
		chk("ref", refo, 16'h0064);
		act = 1'b0;
		term = 16'h03E8;
		step(40);
		term = 16'h0032;
		step(2);
		chk("ref_loss", rloss, 16'h0001);
		chk("ref", refo, 16'h0032);
		term = 16'h03E8;
		$display("test reference loss done");
		load = 8'h96;
		step(20);
		chk("overload_pre", olp, 16'h0000);
		step(25);
		chk("overload_pre", olp, 16'h0001);
		chk("aux", cx, 16'h0001);
		load = 8'h95;
		step(2);
		chk("overload_pre", olp, 16'h0000);
		mol = 8'h51;
		step(2);
		chk("overload_pre", olp, 16'h0001);
		mol = 8'h50;
		step(2);
		chk("overload_pre", olp, 16'h0000);
		$display("test overload done");
		setfn(FN_FEEDBACK_LOSS, FN_HEATSINK_ALARM);
		pid = 1'b1;
		fb_lvl = 16'h01F4;
		fb = 16'h0064;
		fb_dly = 16'h0002;
		step(4);
		chk("feedback_loss", fbl, 16'h0000);
		step(20);
		chk("feedback_loss", fbl, 16'h0001);
		chk("contact_a", ca, 16'h0001);
		pid = 1'b0;
		step(2);
		chk("feedback_loss", fbl, 16'h0000);
		chk("pair_clash", clash, 16'h0000);
		$display("test feedback done");
		// reset with the enable low must still clear everything
		ce_i = 1'b0;
		srst_i = 1'b1;
		step(2);
		srst_i = 1'b0;
		ce_i = 1'b1;
		chk("relay_fn", rfo, 16'h0000);
		chk("aux_fn", afo, 16'h0001);
		chk("contact_a", ca, 16'h0000);
		chk("contact_b", cb, 16'h0001);
		chk("ref", refo, 16'h0000);
		chk("aux_closures", clos, 16'h0000);
		st.forward_run = 1'b1;
		step(2);
		chk("aux", cx, 16'h0001);
		chk("aux_closures", clos, 16'h0001);
		st = '0;
		$display("test mid reset done");
		finish_test();
	end
endmodule : tb_top
